// *** logic/pcmd_pkg.sv ***
// package: register map, field positions, reset values and carrier types of the port command block
// assumes: shared by the command register top and its ahb-lite slave
package pcmd_pkg;

    localparam logic [31:0] PCMD_CMD_OFFSET = 32'h0000_0004;
    localparam logic [31:0] PCMD_STAT_OFFSET = 32'h0000_0008;
    localparam logic [31:0] PCMD_EVT_OFFSET = 32'h0000_000c;

    localparam int PCMD_IO_EN_BIT = 0;
    localparam int PCMD_MEM_EN_BIT = 1;
    localparam int PCMD_BM_EN_BIT = 2;
    localparam int PCMD_PERR_EN_BIT = 6;
    localparam int PCMD_SERR_EN_BIT = 8;
    localparam int PCMD_INTX_DIS_BIT = 10;
    localparam int PCMD_MDPE_BIT = 24;
    localparam int PCMD_SSE_BIT = 30;

    localparam logic [15:0] PCMD_CMD_RESET = 16'h0000;
    localparam logic [15:0] PCMD_CMD_WMASK = 16'h0547;

    localparam logic [1:0] PCMD_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] PCMD_HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic       sel;
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic       hwrite;
        logic [2:0] hsize;
        logic       hready;
        logic [31:0] hwdata;
    } pcmd_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic       hreadyout;
        logic       hresp;
    } pcmd_ahb_rsp_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } pcmd_reg_acc_t;

    typedef struct packed {
        logic io_req;
        logic mem_req;
        logic non_posted;
        logic from_downstream;
    } pcmd_tlp_t;

endpackage

// *** logic/pcmd_ahb_slave.sv ***
// ahb-lite slave front end: turns single word transfers into one-cycle register accesses
// assumes: one master, hready fed back from this slave, zero wait states, okay response always
`timescale 1ns/1ps
module pcmd_ahb_slave (
    input  wire logic                    i_clk,     // core clock
    input  wire logic                    i_rst_b,   // async reset, active low
    input  wire pcmd_pkg::pcmd_ahb_req_t i_req,     // bus request signals
    input  wire logic [31:0]             i_rdata,   // read data from the register file
    output pcmd_pkg::pcmd_ahb_rsp_t      o_rsp,     // bus response signals
    output pcmd_pkg::pcmd_reg_acc_t      o_acc      // decoded access, one cycle
);
    import pcmd_pkg::*;

    logic wr_q, wr_d, rd_q, rd_d;
    logic [31:0] addr_q, addr_d;

    always_comb begin
        wr_d = 1'b0;
        rd_d = 1'b0;
        addr_d = addr_q;
        if (i_req.sel && i_req.hready && (i_req.htrans == PCMD_HTRANS_NONSEQ)) begin
            wr_d = i_req.hwrite;
            rd_d = !i_req.hwrite;
            addr_d = i_req.haddr;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 32'h0000_0000;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            addr_q <= addr_d;
        end
    end

    // write data arrives in the data phase, so the write is applied then
    assign o_acc.wr = wr_q;
    assign o_acc.rd = rd_q;
    assign o_acc.addr = addr_q;
    assign o_acc.wdata = i_req.hwdata;
    assign o_rsp.hrdata = i_rdata;
    assign o_rsp.hreadyout = 1'b1;
    assign o_rsp.hresp = 1'b0;

endmodule

// *** logic/pcmd_top.sv ***
// port command register with its gating of primary, upstream and interrupt traffic
// assumes: one 200 mhz core clock, async active-low fundamental reset, ahb-lite register access
//
// Overview of operation
// - io enable zero ignores primary io requests
// - memory enable zero ignores primary memory requests
// - master enable zero blocks upstream, downstream unsupported
// - rejected non-posted request returns unsupported completion
// - master enable one forwards requests upstream
// - parity response enable gates parity error handling
// - serr enable gates fatal/nonfatal reporting upstream
// - interrupt disable suppresses own intx messages
// - downstream intx forwarding ignores interrupt disable
// - legacy pci bits read zero, not writable
// - signaled system error set on reported message
// - master parity flag never set without enable
`timescale 1ns/1ps
module pcmd_top (
    input  wire logic                    I_MCLK,          // core clock, 200 mhz
    input  wire logic                    I_RST_B,         // async reset, active low
    input  wire pcmd_pkg::pcmd_ahb_req_t I_AHB,           // ahb-lite request
    output pcmd_pkg::pcmd_ahb_rsp_t      O_AHB,           // ahb-lite response
    input  wire pcmd_pkg::pcmd_tlp_t     I_PRI_REQ,       // request arriving on primary side
    output logic                         O_PRI_ACCEPT,    // primary request claimed
    output logic                         O_PRI_IGNORE,    // primary request ignored
    input  wire pcmd_pkg::pcmd_tlp_t     I_DN_REQ,        // request from downstream, heading upstream
    output logic                         O_UP_FWD,        // downstream request forwarded upstream
    output logic                         O_UR_FLAG,       // downstream request handled as unsupported
    output logic                         O_UR_CPL,        // return a completion with unsupported status
    input  wire logic                    I_PARITY_ERR,    // parity error detected on primary side
    output logic                         O_PARITY_ACT,    // take normal parity error action
    input  wire logic                    I_ERR_DET,       // fatal or non-fatal error detected
    output logic                         O_ERR_MSG,       // send error message to root complex
    input  wire logic                    I_OWN_INTX,      // port wants to assert its own intx
    output logic                         O_OWN_INTX,      // own intx message allowed out
    input  wire logic                    I_DN_INTX,       // intx message from downstream port
    output logic                         O_DN_INTX,       // forwarded downstream intx message
    output logic [15:0]                  O_CMD            // current command register value
);
    import pcmd_pkg::*;

    // ****************************************************************
    // bus slave
    // ****************************************************************
    pcmd_reg_acc_t acc;
    logic [31:0] rdata;

    pcmd_ahb_slave i_pcmd_ahb_slave (
        .i_clk   (I_MCLK),
        .i_rst_b (I_RST_B),
        .i_req   (I_AHB),
        .i_rdata (rdata),
        .o_rsp   (O_AHB),
        .o_acc   (acc)
    );

    // ****************************************************************
    // command register and status flags
    // ****************************************************************
    logic [15:0] cmd_q, cmd_d;
    logic mdpe_q, mdpe_d, sse_q, sse_d;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
        hit = (a[31:2] == off[31:2]);
    endfunction

    logic cmd_wr, stat_wr;
    logic err_send, par_set;
    assign cmd_wr = acc.wr && hit(acc.addr, PCMD_CMD_OFFSET);
    assign stat_wr = acc.wr && hit(acc.addr, PCMD_CMD_OFFSET);
    assign err_send = I_ERR_DET && cmd_q[PCMD_SERR_EN_BIT];
    assign par_set = I_PARITY_ERR && cmd_q[PCMD_PERR_EN_BIT];

    always_comb begin
        cmd_d = cmd_q;
        mdpe_d = mdpe_q;
        sse_d = sse_q;
        if (cmd_wr) begin
            // only implemented bits take the write; legacy and reserved stay zero
            cmd_d = acc.wdata[15:0] & PCMD_CMD_WMASK;
        end
        // status half is write-one-to-clear; a same-cycle event wins over the clear
        if (stat_wr && acc.wdata[PCMD_MDPE_BIT]) begin
            mdpe_d = 1'b0;
        end
        if (stat_wr && acc.wdata[PCMD_SSE_BIT]) begin
            sse_d = 1'b0;
        end
        if (par_set) begin
            mdpe_d = 1'b1;
        end
        if (err_send) begin
            sse_d = 1'b1;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            cmd_q <= PCMD_CMD_RESET;
            mdpe_q <= 1'b0;
            sse_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            mdpe_q <= mdpe_d;
            sse_q <= sse_d;
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit(acc.addr, PCMD_CMD_OFFSET)) begin
            rdata[15:0] = cmd_q;
            rdata[PCMD_MDPE_BIT] = mdpe_q;
            rdata[PCMD_SSE_BIT] = sse_q;
        end else if (hit(acc.addr, PCMD_STAT_OFFSET)) begin
            rdata[0] = I_PRI_REQ.io_req;
            rdata[1] = I_PRI_REQ.mem_req;
            rdata[2] = I_DN_REQ.io_req | I_DN_REQ.mem_req;
        end else begin
            rdata = 32'h0000_0000;
        end
    end

    // ****************************************************************
    // traffic gating, registered outputs
    // ****************************************************************
    logic pri_acc_d, pri_ign_d, up_fwd_d, ur_d, ur_cpl_d, par_act_d, err_msg_d, own_d, dn_d;
    logic pri_acc_q, pri_ign_q, up_fwd_q, ur_q, ur_cpl_q, par_act_q, err_msg_q, own_q, dn_q;
    logic pri_any, dn_any, pri_ok, dn_ok;

    always_comb begin
        pri_any = I_PRI_REQ.io_req || I_PRI_REQ.mem_req;
        pri_ok = (I_PRI_REQ.io_req && cmd_q[PCMD_IO_EN_BIT])
              || (I_PRI_REQ.mem_req && cmd_q[PCMD_MEM_EN_BIT]);
        dn_any = I_DN_REQ.io_req || I_DN_REQ.mem_req;
        dn_ok = cmd_q[PCMD_BM_EN_BIT];
        pri_acc_d = pri_ok;
        pri_ign_d = pri_any && !pri_ok;
        up_fwd_d = dn_any && dn_ok;
        ur_d = dn_any && !dn_ok;
        ur_cpl_d = dn_any && !dn_ok && I_DN_REQ.non_posted;
        par_act_d = par_set;
        err_msg_d = err_send;
        own_d = I_OWN_INTX && !cmd_q[PCMD_INTX_DIS_BIT];
        dn_d = I_DN_INTX;
    end

    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pri_acc_q <= 1'b0;
            pri_ign_q <= 1'b0;
            up_fwd_q <= 1'b0;
            ur_q <= 1'b0;
            ur_cpl_q <= 1'b0;
            par_act_q <= 1'b0;
            err_msg_q <= 1'b0;
            own_q <= 1'b0;
            dn_q <= 1'b0;
        end else begin
            pri_acc_q <= pri_acc_d;
            pri_ign_q <= pri_ign_d;
            up_fwd_q <= up_fwd_d;
            ur_q <= ur_d;
            ur_cpl_q <= ur_cpl_d;
            par_act_q <= par_act_d;
            err_msg_q <= err_msg_d;
            own_q <= own_d;
            dn_q <= dn_d;
        end
    end

    assign O_PRI_ACCEPT = pri_acc_q;
    assign O_PRI_IGNORE = pri_ign_q;
    assign O_UP_FWD = up_fwd_q;
    assign O_UR_FLAG = ur_q;
    assign O_UR_CPL = ur_cpl_q;
    assign O_PARITY_ACT = par_act_q;
    assign O_ERR_MSG = err_msg_q;
    assign O_OWN_INTX = own_q;
    assign O_DN_INTX = dn_q;
    assign O_CMD = cmd_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);

    a_io_gate_off: assert property ((I_PRI_REQ.io_req && !I_PRI_REQ.mem_req && !cmd_q[PCMD_IO_EN_BIT])
        |=> (!O_PRI_ACCEPT && O_PRI_IGNORE)) else $error("io request claimed while disabled");
    a_mem_gate_on: assert property ((I_PRI_REQ.mem_req && cmd_q[PCMD_MEM_EN_BIT])
        |=> O_PRI_ACCEPT) else $error("memory request not claimed while enabled");
    a_bm_off_ur: assert property ((I_DN_REQ.mem_req && !cmd_q[PCMD_BM_EN_BIT])
        |=> (O_UR_FLAG && !O_UP_FWD)) else $error("request forwarded while mastering off");
    a_ur_cpl_np: assert property ((I_DN_REQ.io_req && I_DN_REQ.non_posted && !cmd_q[PCMD_BM_EN_BIT])
        |=> O_UR_CPL) else $error("no unsupported completion for non-posted request");
    a_bm_on_fwd: assert property ((I_DN_REQ.io_req && cmd_q[PCMD_BM_EN_BIT])
        |=> (O_UP_FWD && !O_UR_CPL)) else $error("request not forwarded upstream");
    a_parity_gate: assert property ((I_PARITY_ERR && !cmd_q[PCMD_PERR_EN_BIT])
        |=> !O_PARITY_ACT) else $error("parity action while response disabled");
    a_err_report: assert property (I_ERR_DET |=> (O_ERR_MSG == $past(cmd_q[PCMD_SERR_EN_BIT])))
        else $error("error reporting does not follow serr enable");
    a_intx_own: assert property ((I_OWN_INTX && cmd_q[PCMD_INTX_DIS_BIT]) |=> !O_OWN_INTX)
        else $error("own intx sent while disabled");
    a_intx_dn: assert property (I_DN_INTX |=> O_DN_INTX)
        else $error("downstream intx dropped");
    a_fixed_zero: assert property ((cmd_q & ~PCMD_CMD_WMASK) == 16'h0000)
        else $error("hardwired or reserved command bit set");
    a_rsvd_write: assert property (cmd_wr |=> (cmd_q == ($past(acc.wdata[15:0]) & PCMD_CMD_WMASK)))
        else $error("command write stored wrongly");
    a_sse_set: assert property (err_send |=> sse_q)
        else $error("signaled system error not set");
    a_mdpe_never: assert property ((!cmd_q[PCMD_PERR_EN_BIT] && !mdpe_q) |=> !mdpe_q)
        else $error("master parity flag set while disabled");
    a_intx_reset: assert property ($rose(I_RST_B) |-> !cmd_q[PCMD_INTX_DIS_BIT])
        else $error("interrupt disable not clear after reset");

endmodule

// *** test/pcmd_rc_model.sv ***
// pcmd_rc_model: configuration software stand-in, an ahb-lite master doing single word transfers
// assumes: xfer is called just after a rising edge; the one slave's hreadyout is the bus hready
`timescale 1ns/1ps
module pcmd_rc_model (
    input  wire logic                    i_clk, // core clock
    input  wire pcmd_pkg::pcmd_ahb_rsp_t i_rsp, // slave response
    output pcmd_pkg::pcmd_ahb_req_t      o_req  // bus request
);
    import pcmd_pkg::*;
    pcmd_ahb_req_t req_q;

    initial req_q = '0;

    always_comb begin
        o_req = req_q;
        o_req.hready = i_rsp.hreadyout;
    end

    // ************************************************
    // single word transfer
    // ************************************************
    // hready is looked at in the low half before each edge, so the value taken is the one that edge sees
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        logic rdy;
        // hwdata is left alone here: the previous call parked it on its ~wd, a changed pattern only after a write
        req_q.sel <= 1'b1;
        req_q.htrans <= PCMD_HTRANS_NONSEQ;
        req_q.haddr <= a;
        req_q.hwrite <= w;
        req_q.hsize <= PCMD_HSIZE_WORD;
        do begin
            @(negedge i_clk);
            rdy = i_rsp.hreadyout;
            @(posedge i_clk);
        end while (rdy !== 1'b1);
        req_q.sel <= 1'b0;
        req_q.htrans <= 2'h0;
        req_q.hwdata <= w ? wd : ~wd;
        do begin
            @(negedge i_clk);
            rdy = i_rsp.hreadyout;
            rd = i_rsp.hrdata;
            @(posedge i_clk);
        end while (rdy !== 1'b1);
        // released data carries ~wd, a changed pattern after a write; after a read it repeats the data-phase value
        req_q.hwdata <= ~wd;
    endtask
endmodule

// *** test/pcie_bridge_command_register_tb.sv ***
// testbench of the port command block: registers over ahb-lite, gating outputs one cycle after inputs
// assumes: pcmd_rc_model as bus master, 200 mhz clock, async active-low reset
`timescale 1ns/1ps
module pcie_bridge_command_register_tb;
    import pcmd_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    pcmd_ahb_req_t ahb_req;
    pcmd_ahb_rsp_t ahb_rsp;
    pcmd_tlp_t pri_req = '0;
    pcmd_tlp_t dn_req = '0;
    logic [3:0] misc = 4'h0;
    logic [8:0] outs;
    logic [15:0] cmd;
    logic [31:0] rd;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;

    always #2.5 clk = ~clk;

    pcmd_top i_pcmd_top (.I_MCLK(clk), .I_RST_B(rst_b), .I_AHB(ahb_req), .O_AHB(ahb_rsp),
        .I_PRI_REQ(pri_req), .O_PRI_ACCEPT(outs[8]), .O_PRI_IGNORE(outs[7]), .I_DN_REQ(dn_req),
        .O_UP_FWD(outs[6]), .O_UR_FLAG(outs[5]), .O_UR_CPL(outs[4]), .I_PARITY_ERR(misc[3]),
        .O_PARITY_ACT(outs[3]), .I_ERR_DET(misc[2]), .O_ERR_MSG(outs[2]), .I_OWN_INTX(misc[1]),
        .O_OWN_INTX(outs[1]), .I_DN_INTX(misc[0]), .O_DN_INTX(outs[0]), .O_CMD(cmd));
    pcmd_rc_model i_pcmd_rc_model (.i_clk(clk), .i_rsp(ahb_rsp), .o_req(ahb_req));

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0d ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        i_pcmd_rc_model.xfer(1'b1, a, d, rd);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        i_pcmd_rc_model.xfer(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask

    // one cycle of stimulus; outputs {accept,ignore,fwd,ur,urcpl,par,errmsg,own,dn} settle one edge later
    task automatic stim(input pcmd_tlp_t p, input pcmd_tlp_t d, input logic [3:0] m, input logic [8:0] exp);
        pri_req <= p;
        dn_req <= d;
        misc <= m;
        @(posedge clk);
        pri_req <= '0;
        dn_req <= '0;
        misc <= 4'h0;
        #1;
        check({23'h0, outs}, {23'h0, exp});
        @(posedge clk);
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset();
        check({16'h0, cmd}, {16'h0, PCMD_CMD_RESET});
        rdc(PCMD_CMD_OFFSET, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr(PCMD_CMD_OFFSET, 32'h0000_ffff);
        rdc(PCMD_CMD_OFFSET, 32'h0000_0547);
        check({16'h0, cmd}, 32'h0000_0547);
        rdc(PCMD_EVT_OFFSET, 32'h0);
        wr(PCMD_CMD_OFFSET, 32'h0000_fab8);
        rdc(PCMD_CMD_OFFSET, 32'h0);
        pri_req <= 4'h8;
        dn_req <= 4'h4;
        rdc(PCMD_STAT_OFFSET, 32'h0000_0005);
        pri_req <= '0;
        dn_req <= '0;
        $display("test register access done");
    endtask

    task automatic t_primary();
        for (int i = 0; i < 4; i++) begin
            wr(PCMD_CMD_OFFSET, i);
            stim(4'h8, 4'h0, 4'h0, {i[0], ~i[0], 7'h00});
            stim(4'h6, 4'h0, 4'h0, {i[1], ~i[1], 7'h00});
        end
        $display("test primary gating done");
    endtask

    task automatic t_upstream();
        wr(PCMD_CMD_OFFSET, 32'h0);
        stim(4'h0, 4'h7, 4'h0, 9'h030);
        stim(4'h0, 4'h9, 4'h0, 9'h020);
        stim(4'h0, 4'ha, 4'h0, 9'h030);
        wr(PCMD_CMD_OFFSET, 32'h4);
        stim(4'h0, 4'h7, 4'h0, 9'h040);
        stim(4'h0, 4'ha, 4'h0, 9'h040);
        $display("test upstream gating done");
    endtask

    task automatic t_errors();
        wr(PCMD_CMD_OFFSET, 32'h0);
        stim(4'h0, 4'h0, 4'h8, 9'h000);
        stim(4'h0, 4'h0, 4'h4, 9'h000);
        rdc(PCMD_CMD_OFFSET, 32'h0);
        wr(PCMD_CMD_OFFSET, 32'h0000_0140);
        stim(4'h0, 4'h0, 4'h8, 9'h008);
        stim(4'h0, 4'h0, 4'h4, 9'h004);
        rdc(PCMD_CMD_OFFSET, 32'h4100_0140);
        wr(PCMD_CMD_OFFSET, 32'h4100_0140);
        rdc(PCMD_CMD_OFFSET, 32'h0000_0140);
        $display("test error reporting done");
    endtask

    task automatic t_intx();
        wr(PCMD_CMD_OFFSET, 32'h0);
        stim(4'h0, 4'h0, 4'h3, 9'h003);
        wr(PCMD_CMD_OFFSET, 32'h0000_0400);
        stim(4'h0, 4'h0, 4'h3, 9'h001);
        stim(4'h0, 4'h0, 4'h2, 9'h000);
        $display("test interrupt gating done");
    endtask

    // ************************************************
    // main sequence and hang guard
    // ************************************************
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_regs();
        t_primary();
        t_upstream();
        t_errors();
        t_intx();
        complete_run();
    end
endmodule
